// [rtl/lps_pkg.sv]
// constants for the low-power state sequencer (controller side)
// assumes one 100 MHz system clock that also paces the bus clock
package lps_pkg;
  localparam int unsigned clk_mhz = 100;
  // bus clocks after the stop-grant cycle before the sleep request or clock stop
  localparam int unsigned grant_to_stop_bclk = 100;
  // bus clocks between sleep request and bus clock stop
  localparam int unsigned sleep_to_stop_bclk = 10;
  // bus clocks stop-clock request is held after the sleep request is dropped
  localparam int unsigned sleep_to_stop_clock_request_n_bclk = 10;
  // input hold after stop-clock release, in bus clocks
  localparam int unsigned stop_clock_request_n_in_hold_bclk = 8;
  // input hold after sleep release, in bus clocks
  localparam int unsigned sleep_in_hold_bclk = 10;
  // longest pll relock time in microseconds
  localparam int unsigned pll_lock_us = 30;
  localparam int unsigned pll_lock_cyc = pll_lock_us * clk_mhz;
  localparam int unsigned cnt_w = 12;
  typedef enum logic [1:0]
  {
    tgt_stop_grant,
    tgt_quick_start,
    tgt_sleep,
    tgt_deep_sleep
  } target_t;
  typedef enum logic [3:0]
  {
    st_run,
    st_wait_grant,
    st_grant_wait,
    st_stop_grant,
    st_sleep_wait,
    st_sleep,
    st_deep,
    st_relock,
    st_sleep_exit,
    st_stop_clock_request_n_exit,
    st_hold
  } state_t;
endpackage

// [rtl/low_power_state_sequencer.sv]
// controller that steps the processor through its low-power states
// assumes the stop-grant completion pulse is synchronous to mclk and
// that mclk clocks the bus clock gate
// and that the system side honours inputs_frozen and priority_agent_pass;
// every gap is counted in mclk cycles, one bus clock each
`timescale 1ns/1ps
`default_nettype none
module low_power_state_sequencer
  import lps_pkg::*;
#(
  parameter int unsigned pll_wait_cycles = lps_pkg::pll_lock_cyc
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic enter_req,
  input wire lps_pkg::target_t enter_target,
  input wire logic wake_req,
  input wire logic stop_grant_done,
  output logic stop_clock_request_n,
  output logic sleep_request_n,
  output logic bus_clock_enable,
  output logic inputs_frozen,
  output logic priority_agent_pass,
  output logic busy,
  output lps_pkg::state_t state
);
  import lps_pkg::*;

  // state, target and the shared step counter
  state_t state_r;
  state_t state_nxt;
  target_t target_r;
  target_t target_nxt;
  logic [cnt_w-1:0] cnt_r;
  logic [cnt_w-1:0] cnt_nxt;

  // registered request, clock and freeze outputs
  logic stop_clock_request_n_n_r;
  logic stop_clock_request_n_n_nxt;
  logic slp_n_r;
  logic slp_n_nxt;
  logic clk_en_r;
  logic clk_en_nxt;
  logic frozen_r;
  logic frozen_nxt;
  logic pass_r;
  logic pass_nxt;

  // true once the counter has reached one less than the given count
  function automatic logic reached(input logic [cnt_w-1:0] c, input int unsigned n);
    reached = (c >= cnt_w'(n - 1));
  endfunction

  // targets whose inputs the system must freeze at grant completion
  function automatic logic freezes_inputs(input target_t t);
    freezes_inputs = (t != tgt_stop_grant);
  endfunction

  // targets that park in quick start, where the priority request may move
  function automatic logic quick_path(input target_t t);
    quick_path = (t == tgt_quick_start || t == tgt_deep_sleep);
  endfunction

  // next-state and next-output decode

  always_comb
  begin
    state_nxt = state_r;
    target_nxt = target_r;
    cnt_nxt = cnt_r + cnt_w'(1);
    stop_clock_request_n_n_nxt = stop_clock_request_n_n_r;
    slp_n_nxt = slp_n_r;
    clk_en_nxt = clk_en_r;
    frozen_nxt = frozen_r;
    pass_nxt = pass_r;
    case (state_r)
      // idle: bus clock running, inputs free
      st_run:
      begin
        cnt_nxt = '0;
        if (enter_req)
        begin
          target_nxt = enter_target;
          stop_clock_request_n_n_nxt = 1'b0;
          state_nxt = st_wait_grant;
        end
      end

      // stop-clock asserted, waiting for the grant cycle
      st_wait_grant:
      begin
        cnt_nxt = '0;
        if (stop_grant_done)
        begin
          // freeze inputs no later than grant completion
          if (freezes_inputs(target_r))
          begin
            frozen_nxt = 1'b1;
            pass_nxt = quick_path(target_r);
          end
          state_nxt = st_grant_wait;
        end
      end

      // grant seen: count the gap before sleep or clock stop
      st_grant_wait:
      begin
        if (wake_req)
        begin
          cnt_nxt = '0;
          state_nxt = pass_r ? st_stop_clock_request_n_exit : st_hold;
          stop_clock_request_n_n_nxt = pass_r ? stop_clock_request_n_n_r : 1'b1;
        end
        else if (target_r == tgt_stop_grant || target_r == tgt_quick_start)
          state_nxt = st_stop_grant;
        else if (reached(cnt_r, grant_to_stop_bclk))
        begin
          cnt_nxt = '0;
          if (target_r == tgt_sleep || !pass_r)
          begin
            frozen_nxt = 1'b1;
            slp_n_nxt = 1'b0;
            state_nxt = st_sleep_wait;
          end
          else
          begin
            clk_en_nxt = 1'b0;
            state_nxt = st_deep;
          end
        end
      end

      st_stop_grant:
      begin
        // stop grant or quick start: wait here for a wake
        cnt_nxt = '0;
        if (wake_req)
        begin
          if (pass_r)
            state_nxt = st_stop_clock_request_n_exit;
          else
          begin
            stop_clock_request_n_n_nxt = 1'b1;
            state_nxt = st_run;
          end
        end
      end

      // sleep asserted: clock keeps running for the sleep-to-stop gap
      st_sleep_wait:
      begin
        if (wake_req)
        begin
          cnt_nxt = '0;
          slp_n_nxt = 1'b1;
          state_nxt = st_sleep_exit;
        end
        else if (target_r == tgt_deep_sleep && reached(cnt_r, sleep_to_stop_bclk))
        begin
          cnt_nxt = '0;
          clk_en_nxt = 1'b0;
          state_nxt = st_deep;
        end
        else if (target_r != tgt_deep_sleep)
          state_nxt = st_sleep;
      end

      // sleep: a deep-sleep request here stops the clock after the gap
      st_sleep:
      begin
        cnt_nxt = '0;
        if (wake_req)
        begin
          slp_n_nxt = 1'b1;
          state_nxt = st_sleep_exit;
        end
        else if (enter_req && enter_target == tgt_deep_sleep)
        begin
          // the gap is counted afresh, so it is never short
          target_nxt = tgt_deep_sleep;
          state_nxt = st_sleep_wait;
        end
      end

      // bus clock stopped
      st_deep:
      begin
        cnt_nxt = '0;
        if (wake_req)
        begin
          clk_en_nxt = 1'b1;
          state_nxt = st_relock;
        end
      end

      // clock back: wait out the full lock window
      st_relock:
      begin
        // requests stay asserted through the whole lock window
        if (reached(cnt_r, pll_wait_cycles))
        begin
          cnt_nxt = '0;
          if (!slp_n_r)
          begin
            slp_n_nxt = 1'b1;
            state_nxt = st_sleep_exit;
          end
          else
            state_nxt = st_stop_clock_request_n_exit;
        end
      end

      // sleep released: stop-clock stays low for its hold
      st_sleep_exit:
      begin
        if (reached(cnt_r, sleep_to_stop_clock_request_n_bclk))
        begin
          cnt_nxt = '0;
          stop_clock_request_n_n_nxt = 1'b1;
          state_nxt = st_hold;
        end
      end

      st_stop_clock_request_n_exit:
      begin
        cnt_nxt = '0;
        stop_clock_request_n_n_nxt = 1'b1;
        state_nxt = st_hold;
      end

      // stop-clock released: inputs stay frozen for the hold
      st_hold:
      begin
        if (reached(cnt_r, stop_clock_request_n_in_hold_bclk))
        begin
          cnt_nxt = '0;
          frozen_nxt = 1'b0;
          pass_nxt = 1'b0;
          state_nxt = st_run;
        end
      end

      default:
      begin
        state_nxt = st_run;
        cnt_nxt = '0;
      end
    endcase
  end

  // reset leaves the clock running and every request released
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= st_run;
      target_r <= tgt_stop_grant;
      cnt_r <= '0;
      stop_clock_request_n_n_r <= 1'b1;
      slp_n_r <= 1'b1;
      clk_en_r <= 1'b1;
      frozen_r <= 1'b0;
      pass_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      target_r <= target_nxt;
      cnt_r <= cnt_nxt;
      stop_clock_request_n_n_r <= stop_clock_request_n_n_nxt;
      slp_n_r <= slp_n_nxt;
      clk_en_r <= clk_en_nxt;
      frozen_r <= frozen_nxt;
      pass_r <= pass_nxt;
    end
  end

  // outputs come straight from registers, busy decoded from the state register
  assign stop_clock_request_n = stop_clock_request_n_n_r;
  assign sleep_request_n = slp_n_r;
  assign bus_clock_enable = clk_en_r;
  assign inputs_frozen = frozen_r;
  assign priority_agent_pass = pass_r;
  assign busy = (state_r != st_run);
  assign state = state_r;
endmodule
`default_nettype wire

// [tb/lps_monitor.sv]
// checker for the sequencer's request, clock and freeze outputs
// assumes one clock domain, bound onto the sequencer
`timescale 1ns/1ps
`default_nettype none
module lps_monitor
#(
  parameter int unsigned pll_wait_cycles = 20
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic stop_grant_done,
  input wire logic stop_clock_request_n,
  input wire logic sleep_request_n,
  input wire logic bus_clock_enable,
  input wire logic inputs_frozen
);
  wire logic sc = stop_clock_request_n;
  wire logic sl = sleep_request_n;
  wire logic ce = bus_clock_enable;
  wire logic fz = inputs_frozen;
  logic [7:0] g_r;
  logic [15:0] k_r;
  // cycles since the grant pulse and since the clock came back, saturating
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      g_r <= 8'hff;
      k_r <= 16'hffff;
    end
    else
    begin
      g_r <= stop_grant_done ? 8'h00 : g_r + {7'h00, g_r != 8'hff};
      k_r <= !ce ? 16'h0000 : k_r + {15'h0000, k_r != 16'hffff};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_freeze; $rose(fz) |-> $past(stop_grant_done); endproperty
  a_freeze: assert property (p_freeze) else $error("freeze not at grant");
  property p_slp; $fell(sl) |-> g_r >= 8'd100 && fz && !sc; endproperty
  a_slp: assert property (p_slp) else $error("early sleep");
  property p_stop; $fell(ce) |-> g_r >= 8'd100 && (sl || !$past(sl, 10)); endproperty
  a_stop: assert property (p_stop) else $error("early clock stop");
  property p_sc; $rose(sc) |-> $past(sl, 10) && k_r >= pll_wait_cycles; endproperty
  a_sc: assert property (p_sc) else $error("early stop clock release");
  property p_hsc; $rose(sc) && fz |-> fz [*8]; endproperty
  a_hsc: assert property (p_hsc) else $error("short hold after stop clock");
  property p_hsl; $rose(sl) |-> fz [*8] ##1 fz [*2]; endproperty
  a_hsl: assert property (p_hsl) else $error("short hold after sleep");
  property p_lock; $rose(sl) |-> k_r >= pll_wait_cycles; endproperty
  a_lock: assert property (p_lock) else $error("sleep released before lock");
  property p_keep; fz && !sl |=> !sl || $past(ce); endproperty
  a_keep: assert property (p_keep) else $error("sleep dropped while stopped");
  c_sleep: cover property ($fell(sl));
  c_deep: cover property ($fell(ce));
  c_quick: cover property ($rose(sc) && fz);
  c_relock: cover property ($rose(ce));
endmodule
bind low_power_state_sequencer lps_monitor #(.pll_wait_cycles(pll_wait_cycles)) i_lps_monitor
(.mclk, .rstn, .stop_grant_done, .stop_clock_request_n, .sleep_request_n, .bus_clock_enable,
 .inputs_frozen);
`default_nettype wire

// [tb/proc_model.sv]
// processor model: one stop-grant completion pulse per stop-clock request
// assumes the pulse is synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module proc_model
#(
  parameter int unsigned grant_delay = 3
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic stop_clock_request_n,
  output logic stop_grant_done
);
  int unsigned n_r;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      n_r <= 0;
    else
      n_r <= stop_clock_request_n ? 0 : n_r + (n_r <= grant_delay);
  end
  assign stop_grant_done = (n_r == grant_delay);
endmodule
`default_nettype wire

// [tb/low_power_state_sequencer_tb.sv]
// bench for the sequencer against the processor model
// assumes the monitor binds itself onto the sequencer
`timescale 1ns/1ps
`default_nettype none
module low_power_state_sequencer_tb;
  import lps_pkg::*;
  localparam int unsigned pll = 20;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic enter_req = 1'b0;
  target_t enter_target = tgt_stop_grant;
  logic wake_req = 1'b0;
  logic stop_grant_done, stop_clock_request_n, sleep_request_n, bus_clock_enable;
  logic inputs_frozen, priority_agent_pass, busy;
  int fail_count = 0;
  int total_checks = 0;
  int n;
  int m;
  always #5 mclk = ~mclk;
  low_power_state_sequencer #(.pll_wait_cycles(pll)) i_low_power_state_sequencer
  (.mclk, .rstn, .enter_req, .enter_target, .wake_req, .stop_grant_done, .stop_clock_request_n,
   .sleep_request_n, .bus_clock_enable, .inputs_frozen, .priority_agent_pass, .busy, .state());
  proc_model i_proc_model (.mclk, .rstn, .stop_clock_request_n, .stop_grant_done);
  function automatic logic sig(input int k);
    case (k)
      0: return stop_clock_request_n;
      1: return sleep_request_n;
      2: return bus_clock_enable;
      3: return inputs_frozen;
      default: return busy;
    endcase
  endfunction
  task print_verdict;
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %0d seen %0d", s, e, g);
      fail_count++;
    end
  endtask
  // counts edges until the selected output shows v
  task wt(input int k, input logic v);
    n = 0;
    while (sig(k) !== v)
    begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 5000)
      begin
        $display("unexpected wait on output %0d expected %0d seen %0d", k, v, sig(k));
        fail_count++;
        print_verdict;
      end
    end
  endtask
  task go(input target_t t);
    @(posedge mclk);
    enter_req <= 1'b1;
    enter_target <= t;
    @(posedge mclk);
    enter_req <= 1'b0;
    #1;
  endtask
  task wake;
    @(posedge mclk);
    wake_req <= 1'b1;
    @(posedge mclk);
    wake_req <= 1'b0;
    #1;
  endtask
  task t_sleep;
    go(tgt_sleep);
    wt(3, 1'b1);
    wt(1, 1'b0);
    chk("sleep gap", 100, n);
    chk("stop clock", 0, stop_clock_request_n);
    repeat (20) @(posedge mclk);
    chk("clock running", 1, bus_clock_enable);
    wake;
    wt(1, 1'b1);
    wt(0, 1'b1);
    chk("stop clock hold", 10, n);
    m = n;
    wt(3, 1'b0);
    chk("input hold", 8, n);
    chk("sleep input hold", 18, m + n);
  endtask
  // quick start, then deep sleep by stopping the clock
  task t_deep;
    go(tgt_deep_sleep);
    wt(3, 1'b1);
    wt(2, 1'b0);
    chk("clock stop gap", 100, n);
    chk("no sleep", 1, sleep_request_n);
    chk("priority pass", 1, priority_agent_pass);
    wake;
    wt(0, 1'b1);
    chk("relock wait", pll + 1, n);
    wt(3, 1'b0);
    chk("input hold", 8, n);
  endtask
  // sleep, then deep sleep requested from sleep
  task t_sleep_deep;
    go(tgt_sleep);
    wt(1, 1'b0);
    go(tgt_deep_sleep);
    wt(2, 1'b0);
    chk("clock stop gap", 10, n);
    chk("priority pass", 0, priority_agent_pass);
    wake;
    wt(1, 1'b1);
    chk("relock wait", pll, n);
    wt(0, 1'b1);
    chk("stop clock hold", 10, n);
    m = n;
    wt(3, 1'b0);
    chk("sleep input hold", 18, m + n);
  endtask
  task t_quick;
    go(tgt_quick_start);
    wt(3, 1'b1);
    chk("priority pass", 1, priority_agent_pass);
    wake;
    wt(0, 1'b1);
    wt(3, 1'b0);
    chk("input hold", 8, n);
  endtask
  task t_grant;
    go(tgt_stop_grant);
    wt(0, 1'b0);
    go(tgt_sleep);
    repeat (120) @(posedge mclk);
    chk("no sleep", 1, sleep_request_n);
    wake;
    wt(4, 1'b0);
    chk("released", 1, stop_clock_request_n);
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    t_sleep;
    t_deep;
    t_sleep_deep;
    t_quick;
    t_grant;
    print_verdict;
  end
endmodule
`default_nettype wire
